//--- src/arr_pkg.sv
// Constants, carriers and helpers for the accumulated record read-out block
package arr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ARR_OFS_CTRL = 8'h00;
    localparam logic [7:0] ARR_OFS_NACC = 8'h04;
    localparam logic [7:0] ARR_OFS_RLEN = 8'h08;
    localparam logic [7:0] ARR_OFS_CHAN = 8'h0c;
    localparam logic [7:0] ARR_OFS_SEQ = 8'h10;
    localparam logic [7:0] ARR_OFS_STAT = 8'h14;
    localparam int ARR_CTRL_EN_BIT = 0;
    localparam logic [31:0] ARR_NACC_RST = 32'h0000_0001;
    localparam logic [15:0] ARR_RLEN_RST = 16'h0010;
    localparam logic [7:0] ARR_CHAN_RST = 8'h00;

    // ****************************************
    // Record layout
    // ****************************************
    localparam int ARR_ST_ARITH = 3;
    localparam int ARR_ST_LOSS = 2;
    localparam int ARR_ST_QEMPTY = 1;
    localparam int ARR_ST_DROP = 0;
    localparam logic [31:0] ARR_DESC_BYTES = 32'h0000_0020;
    localparam logic [2:0] ARR_DESC_LAST = 3'h7;

    // ****************************************
    // Timing
    // ****************************************
    localparam int ARR_CLK_PERIOD_NS = 20;
    localparam int ARR_REARM_NS = 32;
    localparam int ARR_REARM_RAW = ARR_REARM_NS / ARR_CLK_PERIOD_NS;
    localparam int ARR_REARM_CYC = (ARR_REARM_RAW < 1) ? 1 : ARR_REARM_RAW;

    typedef struct packed {
        logic [63:0] ts;
        logic [31:0] seq;
        logic [31:0] summed;
        logic [3:0] status;
        logic [7:0] chan;
        logic [31:0] addr;
    } arr_desc_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } arr_wr_t;

    typedef enum logic [1:0] {
        ARR_DR_IDLE = 2'b00,
        ARR_DR_SAMP = 2'b01,
        ARR_DR_DESC = 2'b11,
        ARR_DR_PUSH = 2'b10
    } arr_dr_state_t;

    // One 32-bit word of the 32-byte record descriptor
    function automatic logic [31:0] arr_desc_word(input arr_desc_t d,
                                                  input logic [2:0] i);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (i)
            3'h0: w = d.ts[31:0];
            3'h1: w = d.ts[63:32];
            3'h2: w = d.seq;
            3'h3: w = d.summed;
            3'h4: w = {20'h00000, d.chan, d.status};
            3'h5: w = d.addr + ARR_DESC_BYTES;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Register decode shared by write and error paths
    function automatic logic arr_hit(input logic [31:0] a);
        logic h;
        h = 1'b0;
        if (a[31:8] == 24'h000000) begin
            case (a[7:0])
                ARR_OFS_CTRL, ARR_OFS_NACC, ARR_OFS_RLEN,
                ARR_OFS_CHAN, ARR_OFS_SEQ, ARR_OFS_STAT: h = 1'b1;
                default: h = 1'b0;
            endcase
        end
        return h;
    endfunction

endpackage

//--- src/arr_sat32.sv
// Saturating narrowing of a wide accumulated sum to a 32-bit sample
`timescale 1ns/1ps
`default_nettype none
module arr_sat32 #(
    parameter int ACC_W = 40
) (
    // Wide signed sum
    input wire logic [ACC_W-1:0] sum,
    // Narrowed sample and overflow indication
    output logic [31:0] sat,
    output logic ovf
);
    logic hi_ones;
    logic hi_zeros;

    // Fits when all bits above bit 31 repeat the sign of bit 31
    always_comb begin
        hi_ones = &sum[ACC_W-1:31];
        hi_zeros = ~|sum[ACC_W-1:31];
        ovf = !(hi_ones || hi_zeros);
        if (!ovf) begin
            sat = sum[31:0];
        end else if (sum[ACC_W-1]) begin
            sat = 32'h8000_0000;
        end else begin
            sat = 32'h7fff_ffff;
        end
    end
endmodule
`default_nettype wire

//--- src/arr_readout.sv
// Record packager: accumulation tracking, drop policy and record write-out
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module arr_readout import arr_pkg::*; #(
    parameter int ACC_W = 40,
    parameter int RLEN_W = 16
) (
    // Clock, reset and freeze
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Waveform events from the accumulator
    input wire logic wf_trig,
    input wire logic [63:0] wf_timestamp,
    input wire logic wf_end,
    input wire logic wf_summed,
    output logic armed,
    // Accumulator result read port, data valid in the same cycle
    output logic [RLEN_W-1:0] acc_rd_addr,
    input wire logic [ACC_W-1:0] acc_rd_data,
    // Free descriptor queue
    input wire logic free_valid,
    input wire logic [31:0] free_addr,
    output logic free_pop,
    // Write beats towards the host link
    output logic wr_valid,
    output arr_wr_t wr_beat,
    input wire logic wr_ready,
    // Filled descriptor queue
    output logic fill_valid,
    output logic [31:0] fill_addr,
    input wire logic fill_ready
);

    // ****************************************
    // Declarations
    // ****************************************
    logic rst_q1;
    logic rst_n_q;
    logic ctrl_en;
    logic [31:0] nacc;
    logic [RLEN_W-1:0] rlen;
    logic [7:0] chan;
    logic rec_active;
    logic [63:0] rec_ts;
    logic [31:0] rec_seq;
    logic [31:0] seq_ctr;
    logic [31:0] end_cnt;
    logic [31:0] sum_cnt;
    logic holding;
    logic [31:0] hold_addr;
    logic [1:0] rearm_cnt;
    logic pend_drop;
    logic pend_qempty;
    arr_dr_state_t dr_state;
    logic [RLEN_W-1:0] idx;
    arr_desc_t desc;
    logic start;
    logic endev;
    logic complete;
    logic handoff;
    logic drop;
    logic ld;
    logic [31:0] next_end_cnt;
    logic [31:0] next_sum_cnt;
    logic [31:0] sat;
    logic sat_ovf;
    logic apb_wr;
    logic [31:0] buf_base;

    // ****************************************
    // Reset release
    // ****************************************
    // Asynchronous assert, release through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_q1 <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n_q <= rst_q1;
        end
    end

    // ****************************************
    // APB registers
    // ****************************************
    // Zero wait states; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !arr_hit(paddr);
    assign apb_wr = ce && psel && penable && pwrite && arr_hit(paddr);

    // Writable configuration
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_en <= 1'b0;
            nacc <= ARR_NACC_RST;
            rlen <= RLEN_W'(ARR_RLEN_RST);
            chan <= ARR_CHAN_RST;
        end else if (!rst_n_q) begin
            ctrl_en <= 1'b0;
            nacc <= ARR_NACC_RST;
            rlen <= RLEN_W'(ARR_RLEN_RST);
            chan <= ARR_CHAN_RST;
        end else if (apb_wr) begin
            case (paddr[7:0])
                ARR_OFS_CTRL: ctrl_en <= pwdata[ARR_CTRL_EN_BIT];
                ARR_OFS_NACC: nacc <= pwdata;
                ARR_OFS_RLEN: rlen <= pwdata[RLEN_W-1:0];
                ARR_OFS_CHAN: chan <= pwdata[7:0];
                default: ctrl_en <= ctrl_en;
            endcase
        end
    end

    // Read data latched in the setup cycle, stable through the access
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            case (paddr[7:0])
                ARR_OFS_CTRL: prdata <= {31'h0, ctrl_en};
                ARR_OFS_NACC: prdata <= nacc;
                ARR_OFS_RLEN: prdata <= 32'(rlen);
                ARR_OFS_CHAN: prdata <= {24'h000000, chan};
                ARR_OFS_SEQ: prdata <= seq_ctr;
                ARR_OFS_STAT: prdata <= {26'h0, dr_state != ARR_DR_IDLE,
                                         armed, rec_active, holding,
                                         pend_qempty, pend_drop};
                default: prdata <= 32'h0000_0000;
            endcase
            if (paddr[31:8] != 24'h000000) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // Accumulation tracking
    // ****************************************
    assign armed = ctrl_en && (rearm_cnt == 2'b00);
    assign start = ce && wf_trig && armed && !rec_active;
    assign endev = ce && wf_end && rec_active;
    assign next_end_cnt = end_cnt + 32'h1;
    assign next_sum_cnt = sum_cnt + {31'h0, wf_summed};
    // A zero count behaves as one so a record always closes
    assign complete = endev && (next_end_cnt >= nacc);
    // Hand over only with a buffer and an idle write-out; otherwise drop
    assign handoff = complete && holding && (dr_state == ARR_DR_IDLE);
    assign drop = complete && !handoff;
    // Earliest queued address taken as the record starts
    assign free_pop = start && !holding && free_valid;

    // Record counters, timestamp and sequence
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rec_active <= 1'b0;
            rec_ts <= 64'h0;
            rec_seq <= 32'h0;
            seq_ctr <= 32'h0;
            end_cnt <= 32'h0;
            sum_cnt <= 32'h0;
        end else if (!rst_n_q) begin
            rec_active <= 1'b0;
            seq_ctr <= 32'h0;
        end else if (start) begin
            rec_active <= 1'b1;
            rec_ts <= wf_timestamp;
            rec_seq <= seq_ctr + 32'h1;
            seq_ctr <= seq_ctr + 32'h1;
            end_cnt <= 32'h0;
            sum_cnt <= 32'h0;
        end else if (endev) begin
            // Record spans exactly the grid count, lost ones included
            end_cnt <= next_end_cnt;
            sum_cnt <= next_sum_cnt;
            if (complete) begin
                rec_active <= 1'b0;
            end
        end
    end

    // Buffer ownership; a dropped record keeps its buffer for the next
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            holding <= 1'b0;
            hold_addr <= 32'h0;
        end else if (!rst_n_q) begin
            holding <= 1'b0;
        end else if (ce) begin
            if (free_pop) begin
                holding <= 1'b1;
                hold_addr <= free_addr;
            end else if (handoff) begin
                holding <= 1'b0;
            end
        end
    end

    // Rearm gap after each completed record
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rearm_cnt <= 2'b00;
        end else if (!rst_n_q) begin
            rearm_cnt <= 2'b00;
        end else if (ce) begin
            if (complete) begin
                rearm_cnt <= 2'(ARR_REARM_CYC);
            end else if (rearm_cnt != 2'b00) begin
                rearm_cnt <= rearm_cnt - 2'b01;
            end
        end
    end

    // Pending health flags since the last delivery; set beats clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pend_drop <= 1'b0;
            pend_qempty <= 1'b0;
        end else if (!rst_n_q) begin
            pend_drop <= 1'b0;
            pend_qempty <= 1'b0;
        end else if (ce) begin
            if (drop) begin
                pend_drop <= 1'b1;
            end else if (handoff) begin
                pend_drop <= 1'b0;
            end
            // Only a queue stall marks this flag, never a link stall
            if (start && !holding && !free_valid) begin
                pend_qempty <= 1'b1;
            end else if (handoff) begin
                pend_qempty <= 1'b0;
            end
        end
    end

    // ****************************************
    // Record write-out
    // ****************************************
    // Samples are narrowed here so a sum too wide for 32 bits saturates instead of wrapping
    arr_sat32 #(
        .ACC_W(ACC_W)
    ) u_sat (
        .sum(acc_rd_data),
        .sat(sat),
        .ovf(sat_ovf)
    );

    assign acc_rd_addr = idx;
    assign ld = !wr_valid || wr_ready;
    assign buf_base = desc.addr + ARR_DESC_BYTES;
    // Push only after the last descriptor beat has been accepted
    assign fill_valid = (dr_state == ARR_DR_PUSH) && !wr_valid;
    assign fill_addr = desc.addr;

    // Samples first, then descriptor, then the filled-queue push
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dr_state <= ARR_DR_IDLE;
            idx <= '0;
            desc <= '0;
            wr_valid <= 1'b0;
            wr_beat <= '0;
        end else if (!rst_n_q) begin
            dr_state <= ARR_DR_IDLE;
            idx <= '0;
            wr_valid <= 1'b0;
        end else if (ce) begin
            if (wr_valid && wr_ready) begin
                wr_valid <= 1'b0;
            end
            case (dr_state)
                ARR_DR_IDLE: begin
                    if (handoff) begin
                        desc.ts <= rec_ts;
                        desc.seq <= rec_seq;
                        desc.summed <= next_sum_cnt;
                        desc.status[ARR_ST_ARITH] <= 1'b0;
                        desc.status[ARR_ST_LOSS] <=
                            (next_sum_cnt < nacc);
                        desc.status[ARR_ST_QEMPTY] <= pend_qempty;
                        desc.status[ARR_ST_DROP] <= pend_drop;
                        desc.chan <= chan;
                        desc.addr <= hold_addr;
                        idx <= '0;
                        dr_state <= ARR_DR_SAMP;
                    end
                end
                ARR_DR_SAMP: begin
                    if (ld) begin
                        wr_beat.addr <= buf_base + 32'({idx, 2'b00});
                        wr_beat.data <= sat;
                        wr_valid <= 1'b1;
                        if (sat_ovf) begin
                            desc.status[ARR_ST_ARITH] <= 1'b1;
                        end
                        if (32'(idx) + 32'h1 >= 32'(rlen)) begin
                            idx <= '0;
                            dr_state <= ARR_DR_DESC;
                        end else begin
                            idx <= idx + RLEN_W'(1);
                        end
                    end
                end
                ARR_DR_DESC: begin
                    if (ld) begin
                        wr_beat.addr <= desc.addr + 32'({idx[2:0], 2'b00});
                        wr_beat.data <= arr_desc_word(desc, idx[2:0]);
                        wr_valid <= 1'b1;
                        if (idx[2:0] == ARR_DESC_LAST) begin
                            idx <= '0;
                            dr_state <= ARR_DR_PUSH;
                        end else begin
                            idx <= idx + RLEN_W'(1);
                        end
                    end
                end
                ARR_DR_PUSH: begin
                    if (fill_valid && fill_ready) begin
                        dr_state <= ARR_DR_IDLE;
                    end
                end
                default: dr_state <= ARR_DR_IDLE;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_seq_advance: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        start |=> (seq_ctr == $past(seq_ctr) + 32'h1))
        else $error("sequence count did not advance at record start");
    a_ts_capture: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        start |=> (rec_ts == $past(wf_timestamp)))
        else $error("timestamp not taken from first waveform");
    a_loss_flag: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        handoff |=> (desc.status[ARR_ST_LOSS] ==
                     ($past(next_sum_cnt) < $past(nacc))))
        else $error("loss flag disagrees with summed count");
    a_qempty_flag: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (start && !holding && !free_valid) |=> pend_qempty && !holding)
        else $error("empty free queue not flagged");
    a_drop_flag: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        drop |=> pend_drop && $stable(desc.ts) && $stable(desc.seq) &&
                 $stable(desc.summed) && $stable(desc.addr))
        else $error("dropped record not flagged or waiting record disturbed");
    a_rearm_gap: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (complete ##1 (ce && ctrl_en)) |=> armed)
        else $error("not rearmed within the rearm time");
    a_push_last: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (fill_valid && !fill_ready && ce) |=> fill_valid && !wr_valid)
        else $error("filled push withdrawn or overlapping a write");
    a_beat_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (wr_valid && !wr_ready) |=> wr_valid && $stable(wr_beat))
        else $error("write beat changed while stalled");
    a_flags_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (handoff && !(start && !holding)) |=> !pend_drop && !pend_qempty)
        else $error("health flags carried past a delivery");
    a_arith_flag: assert property (
        @(posedge core_clk) disable iff (!rst_n_q)
        (ce && dr_state == ARR_DR_SAMP && ld && sat_ovf) |=>
            desc.status[ARR_ST_ARITH] && (wr_beat.data == 32'h7fff_ffff ||
                                          wr_beat.data == 32'h8000_0000))
        else $error("overflowed sample not saturated or flagged");

endmodule
`default_nettype wire

//--- sim/arr_host_model.sv
// Host side model: free and filled descriptor queues plus host memory
`timescale 1ns/1ps
`default_nettype none
module arr_host_model import arr_pkg::*; (
    // Clock and bench controls
    input wire logic core_clk,
    input wire logic stall,
    input wire logic starve,
    // Free descriptor queue
    output logic free_valid,
    output logic [31:0] free_addr,
    input wire logic free_pop,
    // Write stream and filled queue
    input wire logic wr_valid,
    input wire arr_wr_t wr_beat,
    output logic wr_ready,
    input wire logic fill_valid,
    input wire logic [31:0] fill_addr,
    output logic fill_ready
);
    // Descriptor slots 4 KiB apart hold 32 bytes plus the samples
    logic [31:0] q[$] = '{32'h1000, 32'h2000, 32'h3000};
    logic [31:0] mem[logic [31:0]];
    logic [31:0] last = 32'h0;
    logic [31:0] gone = 32'h0;
    int nfill = 0;
    initial free_valid = 1'h0;
    initial wr_ready = 1'h0;
    initial fill_ready = 1'h0;

    // Word at an offset inside the last filled descriptor slot
    function automatic logic [31:0] word(input logic [31:0] ofs);
        return mem[last + ofs];
    endfunction

    // Queue, memory and backpressure; released head shows inverted data
    always @(posedge core_clk) begin
        if (free_pop && q.size() > 0) gone = q.pop_front();
        if (wr_valid && wr_ready) mem[wr_beat.addr] = wr_beat.data;
        if (fill_valid && fill_ready) begin
            last = fill_addr;
            nfill++;
            q.push_back(fill_addr);
        end
        free_valid <= q.size() > 0 && !starve;
        free_addr <= (q.size() > 0 && !starve) ? q[0] : ~gone;
        wr_ready <= !stall;
        fill_ready <= !stall;
    end
endmodule
`default_nettype wire

//--- sim/accumulated_record_readout_test.sv
// Self-checking bench of the record read-out block
`timescale 1ns/1ps
`default_nettype none
module accumulated_record_readout_test;
    import arr_pkg::*;
    logic core_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, er, armed, sat = 1'h0;
    logic wf_trig = 1'h0, wf_end = 1'h0, wf_summed = 1'h0;
    logic stall = 1'h0, starve = 1'h0, free_valid, free_pop;
    logic ce = 1'h1;
    logic wr_valid, wr_ready, fill_valid, fill_ready;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [31:0] free_addr, fill_addr;
    logic [63:0] wf_timestamp = 64'h0;
    logic [15:0] acc_rd_addr;
    logic [39:0] acc_rd_data;
    arr_wr_t wr_beat;
    int n_errors = 0, samples_checked = 0, nf = 0;

    // Sums are index plus one, or a positive sum too wide for 32 bits
    assign acc_rd_data = sat ? 40'h7f_ffff_ffff : {24'h0, acc_rd_addr} + 40'h1;
    initial forever #10 core_clk = ~core_clk;

    arr_readout arr_readout_i (.core_clk(core_clk), .rstn(rstn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wf_trig(wf_trig), .wf_timestamp(wf_timestamp), .wf_end(wf_end),
        .wf_summed(wf_summed), .armed(armed), .acc_rd_addr(acc_rd_addr),
        .acc_rd_data(acc_rd_data), .free_valid(free_valid),
        .free_addr(free_addr), .free_pop(free_pop), .wr_valid(wr_valid),
        .wr_beat(wr_beat), .wr_ready(wr_ready), .fill_valid(fill_valid),
        .fill_addr(fill_addr), .fill_ready(fill_ready));
    arr_host_model arr_host_model_i (.core_clk(core_clk), .stall(stall),
        .starve(starve), .free_valid(free_valid), .free_addr(free_addr),
        .free_pop(free_pop), .wr_valid(wr_valid), .wr_beat(wr_beat),
        .wr_ready(wr_ready), .fill_valid(fill_valid), .fill_addr(fill_addr),
        .fill_ready(fill_ready));

    task finish_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'h1) break;
        end
        if (i == 20) n_errors++;
        if (i == 20) finish_test();
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // One record of two waveforms; sm says which are summed
    task rec(input logic [63:0] ts, input logic [1:0] sm);
        int i, k;
        @(posedge core_clk);
        // Triggers only while armed keep the output rate within the link
        for (i = 0; i < 20 && armed !== 1'h1; i++) @(posedge core_clk);
        check({31'h0, i <= ARR_REARM_CYC + 2}, 32'h1);
        if (i == 20) finish_test();
        for (k = 0; k < 2; k++) begin
            wf_trig <= 1'h1;
            wf_timestamp <= ts + 64'(k);
            @(posedge core_clk);
            wf_trig <= 1'h0;
            wf_end <= 1'h1;
            wf_summed <= sm[k];
            @(posedge core_clk);
            wf_end <= 1'h0;
        end
    endtask

    // Wait for the next descriptor pushed into the filled queue
    task wfill;
        int i;
        for (i = 0; i < 400 && arr_host_model_i.nfill == nf; i++)
            @(posedge core_clk);
        if (i == 400) n_errors++;
        if (i == 400) finish_test();
        nf++;
    endtask

    // Compare the delivered descriptor and its first two samples
    task chk(input logic [31:0] sq, input logic [31:0] sm,
             input logic [3:0] st, input logic [63:0] ts,
             input logic [31:0] s0, input logic [31:0] s1,
             input logic [31:0] ad);
        check(arr_host_model_i.last, ad);
        check(arr_host_model_i.word(32'h0), ts[31:0]);
        check(arr_host_model_i.word(32'h4), ts[63:32]);
        check(arr_host_model_i.word(32'h8), sq);
        check(arr_host_model_i.word(32'hc), sm);
        check(arr_host_model_i.word(32'h10), {20'h0, 8'h05, st});
        check(arr_host_model_i.word(32'h14), ad + ARR_DESC_BYTES);
        check(arr_host_model_i.word(32'h20), s0);
        check(arr_host_model_i.word(32'h24), s1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge core_clk);
        apb(1'h0, ARR_OFS_NACC, 32'h0);
        check(rd, ARR_NACC_RST);
        apb(1'h0, ARR_OFS_RLEN, 32'h0);
        check(rd, {16'h0, ARR_RLEN_RST});
        apb(1'h0, 8'h40, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'h1, ARR_OFS_NACC, 32'h2);
        apb(1'h1, ARR_OFS_RLEN, 32'h2);
        apb(1'h1, ARR_OFS_CHAN, 32'h5);
        // A write while the block is frozen must leave the register alone
        ce <= 1'h0;
        apb(1'h1, ARR_OFS_CHAN, 32'h9);
        ce <= 1'h1;
        apb(1'h0, ARR_OFS_CHAN, 32'h0);
        check(rd, 32'h5);
        apb(1'h1, ARR_OFS_CTRL, 32'h1);
        rec(64'h0123_4567_89ab_cdef, 2'h3);
        wfill();
        check(arr_host_model_i.last, 32'h1000);
        chk(32'h1, 32'h2, 4'h0, 64'h0123_4567_89ab_cdef, 32'h1, 32'h2,
            32'h1000);
        rec(64'h2000, 2'h1);
        wfill();
        chk(32'h2, 32'h1, 4'h4, 64'h2000, 32'h1, 32'h2, 32'h2000);
        sat <= 1'h1;
        rec(64'h3000, 2'h3);
        wfill();
        sat <= 1'h0;
        chk(32'h3, 32'h2, 4'h8, 64'h3000, 32'h7fff_ffff, 32'h7fff_ffff,
            32'h3000);
        stall <= 1'h1;
        rec(64'h4000, 2'h3);
        rec(64'h5000, 2'h3);
        stall <= 1'h0;
        wfill();
        chk(32'h4, 32'h2, 4'h0, 64'h4000, 32'h1, 32'h2, 32'h1000);
        rec(64'h6000, 2'h3);
        wfill();
        chk(32'h6, 32'h2, 4'h1, 64'h6000, 32'h1, 32'h2,
            32'h2000);
        starve <= 1'h1;
        rec(64'h7000, 2'h3);
        starve <= 1'h0;
        rec(64'h8000, 2'h3);
        wfill();
        chk(32'h8, 32'h2, 4'h3, 64'h8000, 32'h1, 32'h2, 32'h3000);
        apb(1'h0, ARR_OFS_SEQ, 32'h0);
        check(rd, 32'h8);
        finish_test();
    end
endmodule
`default_nettype wire
